// *** src/fcd_exec.sv ***
/*
  Four-phase execution of the complement, decrement and
  decrement-skip-if-zero file instructions. One instruction slot
  takes four clocks, one per phase, and every result lands on the
  clock that closes Q4.
  Assumes the instruction word is valid at Q1 and the file read data
  answers the address one clock later, within Q2.
  Assumes the surrounding core owns fetch, the program counter and
  the file memory, and takes the write strobe in the Q1 after Q4.
  Assumes instruction and file data come from logic on this clock,
  so no synchronising stages sit in front of them.
*/
`timescale 1ns/1ps
`include "fcd_exec_cfg.svh"
module fcd_exec (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  // Instruction slot
  input  wire logic [13:0] instr_in,
  // File read data
  input  wire logic [7:0]  file_rd_data_in,
  // Phase and cycle status
  output logic [3:0]       phase_out,
  output logic             cycle_end_out,
  output logic             nop_cycle_out,
  output logic             busy_out,
  // File access
  output logic [6:0]       file_addr_out,
  output logic             file_wr_en_out,
  output logic [7:0]       file_wr_data_out,
  // Working register and zero flag
  output logic [7:0]       w_out,
  output logic             zero_flag_out
);
  fcd_exec_pkg::fcd_state_type s_q;
  fcd_exec_pkg::fcd_state_type s_d;
  logic [7:0]                  alu_res;
  logic                        alu_zero;
  logic [1:0]                  op_hi;
  logic [3:0]                  op_code;
  logic                        op_dest;
  logic [6:0]                  op_addr;
  logic                        is_cpl;
  logic                        is_dec;
  logic                        is_dsz;
  logic                        is_mine;
  logic                        op_live;
  logic                        wb_file;
  logic                        wb_w;
  logic                        z_upd;
  logic                        skip_arm;

  // Result unit sees the latched operand and operation
  fcd_alu u_alu (
    .alu_in   (s_q.alu),
    .opnd_in  (s_q.opnd),
    .res_out  (alu_res),
    .zero_out (alu_zero)
  );

  assign op_hi   = instr_in[13:12];
  assign op_code = instr_in[11:8];
  assign op_dest = instr_in[`FCD_DEST_BIT];
  assign op_addr = instr_in[6:0];

  // Opcode decode; words outside the group decode to nothing
  always_comb begin
    is_cpl = 1'b0;
    is_dec = 1'b0;
    is_dsz = 1'b0;
    case (op_code)
      `FCD_OP_COMPLEMENT_FILE: begin
        is_cpl = (op_hi == `FCD_OP_HI);
      end
      `FCD_OP_DECREMENT_FILE: begin
        is_dec = (op_hi == `FCD_OP_HI);
      end
      `FCD_OP_DECREMENT_SKIP_ZERO: begin
        is_dsz = (op_hi == `FCD_OP_HI);
      end
      default: begin
        is_cpl = 1'b0;
      end
    endcase
  end
  assign is_mine = is_cpl | is_dec | is_dsz;

  assign op_live  = (s_q.alu != fcd_exec_pkg::FCD_NONE) && !s_q.nop_cyc;
  assign wb_file  = op_live && (s_q.dest == `FCD_DEST_F);
  assign wb_w     = op_live && (s_q.dest == `FCD_DEST_W);
  assign z_upd    = op_live && !s_q.skip_op;
  assign skip_arm = op_live && s_q.skip_op && alu_zero;

  always_comb begin
    // Hold every field unless a phase below changes it
    s_d = s_q;
    // Write strobe and cycle mark are one-clock pulses
    s_d.fwr.wr_en = 1'b0;
    s_d.cyc_done = 1'b0;
    case (s_q.phase)
      fcd_exec_pkg::FCD_Q1: begin
        s_d.phase = fcd_exec_pkg::FCD_Q2;
        if (s_q.skip_pend) begin
          // Drop the fetched word: no W, flag or file change
          s_d.skip_pend = 1'b0;
          s_d.nop_cyc = 1'b1;
          s_d.alu = fcd_exec_pkg::FCD_NONE;
          s_d.skip_op = 1'b0;
          s_d.busy = 1'b0;
        end else begin
          s_d.nop_cyc = 1'b0;
          s_d.skip_op = is_dsz;
          s_d.addr = op_addr;
          s_d.dest = op_dest;
          s_d.busy = is_mine;
          if (is_cpl) begin
            s_d.alu = fcd_exec_pkg::FCD_CPL;
          end else if (is_dec || is_dsz) begin
            s_d.alu = fcd_exec_pkg::FCD_DEC;
          end else begin
            s_d.alu = fcd_exec_pkg::FCD_NONE;
          end
        end
      end
      fcd_exec_pkg::FCD_Q2: begin
        s_d.phase = fcd_exec_pkg::FCD_Q3;
        if (!s_q.nop_cyc) begin
          s_d.opnd = file_rd_data_in;
        end
      end
      fcd_exec_pkg::FCD_Q3: begin
        s_d.phase = fcd_exec_pkg::FCD_Q4;
        if (!s_q.nop_cyc) begin
          s_d.res = alu_res;
        end
      end
      fcd_exec_pkg::FCD_Q4: begin
        s_d.phase = fcd_exec_pkg::FCD_Q1;
        s_d.cyc_done = 1'b1;
        if (wb_file) begin
          s_d.fwr.wr_en = 1'b1;
          s_d.fwr.addr = s_q.addr;
          s_d.fwr.data = s_q.res;
        end
        if (wb_w) begin
          s_d.w = s_q.res;
        end
        // Zero comes from the unit, which still holds the Q3 operand
        if (z_upd) begin
          s_d.zero = alu_zero;
        end
        if (op_live) begin
          s_d.skip_pend = skip_arm;
        end
      end
      // Illegal phase code: drop the slot, restart at Q1
      default: begin
        s_d.phase = fcd_exec_pkg::FCD_Q1;
        s_d.skip_pend = 1'b0;
        s_d.nop_cyc = 1'b0;
        s_d.alu = fcd_exec_pkg::FCD_NONE;
        s_d.skip_op = 1'b0;
        s_d.busy = 1'b0;
      end
    endcase

    // Reset last, so it overrides every phase
    if (srst_in) begin
      s_d.phase = fcd_exec_pkg::FCD_Q1;
      s_d.skip_pend = 1'b0;
      s_d.nop_cyc = 1'b0;
      s_d.alu = fcd_exec_pkg::FCD_NONE;
      s_d.skip_op = 1'b0;
      s_d.dest = `FCD_DEST_W;
      s_d.addr = 7'h00;
      s_d.opnd = 8'h00;
      s_d.res = 8'h00;
      s_d.w = `FCD_W_RESET;
      s_d.zero = 1'b0;
      s_d.busy = 1'b0;
      s_d.cyc_done = 1'b0;
      s_d.fwr.wr_en = 1'b0;
      s_d.fwr.addr = 7'h00;
      s_d.fwr.data = 8'h00;
    end
  end

  // One register stage holds the whole state
  always_ff @(posedge clk_sys_in) begin
    s_q <= s_d;
  end

  // Outputs are plain taps of the state register
  // Phase and cycle status
  assign phase_out        = s_q.phase;
  assign cycle_end_out    = s_q.cyc_done;
  assign nop_cycle_out    = s_q.nop_cyc;
  assign busy_out         = s_q.busy;
  // File access
  assign file_addr_out    = s_q.addr;
  assign file_wr_en_out   = s_q.fwr.wr_en;
  assign file_wr_data_out = s_q.fwr.data;
  // Working register and zero flag
  assign w_out            = s_q.w;
  assign zero_flag_out    = s_q.zero;
endmodule

// *** src/fcd_exec_cfg.svh ***
/*
  Timing, encoding and reset constants for the file complement and
  decrement execution unit. Assumes a 14-bit instruction word.
*/
`ifndef FCD_EXEC_CFG_SVH
`define FCD_EXEC_CFG_SVH
`define FCD_OP_HI                  2'h0
`define FCD_OP_COMPLEMENT_FILE     4'h9
`define FCD_OP_DECREMENT_FILE      4'h3
`define FCD_OP_DECREMENT_SKIP_ZERO 4'hB
`define FCD_DEST_W                 1'h0
`define FCD_DEST_F                 1'h1
`define FCD_DEST_BIT               7
`define FCD_W_RESET                8'h00
`define FCD_PHASES                 4
`endif

// *** src/fcd_exec_pkg.sv ***
/*
  Types for the file complement and decrement execution unit.
  Assumes the cfg header is included by the design files.
*/
package fcd_exec_pkg;
  typedef enum logic [3:0] {
    FCD_Q1 = 4'h1,
    FCD_Q2 = 4'h2,
    FCD_Q3 = 4'h4,
    FCD_Q4 = 4'h8
  } fcd_phase_type;

  typedef enum logic [2:0] {
    FCD_NONE = 3'h1,
    FCD_CPL  = 3'h2,
    FCD_DEC  = 3'h4
  } fcd_alu_type;

  typedef struct packed {
    logic       wr_en;
    logic [6:0] addr;
    logic [7:0] data;
  } fcd_file_wr_type;

  typedef struct packed {
    fcd_phase_type   phase;
    logic            skip_pend;
    logic            nop_cyc;
    fcd_alu_type     alu;
    logic            skip_op;
    logic            dest;
    logic [6:0]      addr;
    logic [7:0]      opnd;
    logic [7:0]      res;
    logic [7:0]      w;
    logic            zero;
    logic            busy;
    logic            cyc_done;
    fcd_file_wr_type fwr;
  } fcd_state_type;
endpackage

// *** src/fcd_alu.sv ***
/*
  Combinational result unit: complement or decrement of one byte.
  Assumes the caller selects the operation from a decoded opcode.
*/
`timescale 1ns/1ps
`include "fcd_exec_cfg.svh"
module fcd_alu (
  // Operation and operand
  input  wire fcd_exec_pkg::fcd_alu_type alu_in,
  input  wire logic [7:0]                opnd_in,
  // Result
  output logic [7:0]                     res_out,
  output logic                           zero_out
);
  always_comb begin
    case (alu_in)
      fcd_exec_pkg::FCD_CPL: res_out = ~opnd_in;
      fcd_exec_pkg::FCD_DEC: res_out = opnd_in - 8'h01;
      default:               res_out = opnd_in;
    endcase
    zero_out = (res_out == 8'h00);
  end
endmodule

// *** test/fcd_exec_sva.sv ***
/* Port checker for fcd_exec.
   Assumes it is bound to the design's top module. */
`timescale 1ns/1ps
module fcd_exec_sva (
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        srst_in,
  // Watched ports
  input wire logic [13:0] instr_in,
  input wire logic [7:0]  file_rd_data_in,
  input wire logic [3:0]  phase_out,
  input wire logic        cycle_end_out,
  input wire logic        nop_cycle_out,
  input wire logic        busy_out,
  input wire logic [6:0]  file_addr_out,
  input wire logic        file_wr_en_out,
  input wire logic [7:0]  w_out,
  input wire logic        zero_flag_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  sequence s_dec;
    phase_out == 4'h1 ##1 busy_out;
  endsequence
  sequence s_skip;
    phase_out == 4'h1 && instr_in[13:8] == 6'h0B ##1 busy_out;
  endsequence
  a_phase_q1q2: assert property (phase_out == 4'h1 |=> phase_out == 4'h2)
    else $error("phase after Q1");
  a_q4_wraps: assert property (phase_out == 4'h8 |=> phase_out == 4'h1 && cycle_end_out)
    else $error("phase after Q4");
  a_wr_in_q1: assert property (file_wr_en_out |-> phase_out == 4'h1 && cycle_end_out)
    else $error("write outside Q1");
  a_nop_no_wr: assert property (nop_cycle_out |-> !file_wr_en_out)
    else $error("write in skipped cycle");
  a_nop_hold: assert property (nop_cycle_out && phase_out == 4'h2
    |=> ($stable(w_out) && $stable(zero_flag_out))[*3]) else $error("skip changed state");
  a_skip_z_keep: assert property (s_skip |=> $stable(zero_flag_out)[*3])
    else $error("skip form changed Z");
  a_addr_latch: assert property (s_dec |-> file_addr_out == $past(instr_in[6:0]))
    else $error("file address");
  a_bad_op: assert property (phase_out == 4'h1 && instr_in[13:12] != 2'h0 |=> !busy_out)
    else $error("foreign opcode taken");
  a_skip_taken: assert property (s_skip ##0 file_rd_data_in == 8'h01 |-> ##4 nop_cycle_out)
    else $error("zero result no skip");
  a_skip_not: assert property (s_skip ##0 file_rd_data_in != 8'h01 |-> ##4 !nop_cycle_out)
    else $error("nonzero result skipped");
endmodule
bind fcd_exec fcd_exec_sva chk_u (
  .clk_sys_in      (clk_sys_in),
  .srst_in         (srst_in),
  .instr_in        (instr_in),
  .file_rd_data_in (file_rd_data_in),
  .phase_out       (phase_out),
  .cycle_end_out   (cycle_end_out),
  .nop_cycle_out   (nop_cycle_out),
  .busy_out        (busy_out),
  .file_addr_out   (file_addr_out),
  .file_wr_en_out  (file_wr_en_out),
  .w_out           (w_out),
  .zero_flag_out   (zero_flag_out)
);

// *** test/test_file_complement_decrement_exec.sv ***
/* Self-checking bench for fcd_exec.
   Assumes the bench alone drives the design's inputs. */
`timescale 1ns/1ps
module test_file_complement_decrement_exec;
  logic        clk_sys_in = 1'b0, srst_in = 1'b1;
  logic [13:0] instr_in = 14'h0000;
  logic [7:0]  file_rd_data_in = 8'h00, w_out, file_wr_data_out;
  logic [6:0]  file_addr_out;
  logic [3:0]  phase_out;
  logic        cycle_end_out, nop_cycle_out, busy_out, file_wr_en_out, zero_flag_out;
  logic [5:0]  ops [5] = '{6'h09, 6'h03, 6'h0B, 6'h0A, 6'h1B};
  logic [7:0]  d;
  int          error_cnt = 0, check_count = 0, w = 0, z = 0, skip = 0, r;
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", n, e, s); end end
  always #4 clk_sys_in = ~clk_sys_in;
  fcd_exec dut_u (
    .clk_sys_in       (clk_sys_in),
    .srst_in          (srst_in),
    .instr_in         (instr_in),
    .file_rd_data_in  (file_rd_data_in),
    .phase_out        (phase_out),
    .cycle_end_out    (cycle_end_out),
    .nop_cycle_out    (nop_cycle_out),
    .busy_out         (busy_out),
    .file_addr_out    (file_addr_out),
    .file_wr_en_out   (file_wr_en_out),
    .file_wr_data_out (file_wr_data_out),
    .w_out            (w_out),
    .zero_flag_out    (zero_flag_out)
  );
  task end_of_test;
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One instruction slot, then compare with the model
  task op(input logic [13:0] i, input logic [7:0] v);
    instr_in = i;
    file_rd_data_in = v;
    repeat (4) @(posedge clk_sys_in);
    #1;
    r = ((i[13:8] == 6'h09) ? ~v : v - 1) & 255;
    `CHK("nop", skip, nop_cycle_out)
    `CHK("phase", 1, phase_out)
    `CHK("cyc_end", 1, cycle_end_out)
    if (skip) begin
      `CHK("skip_wr_en", 0, file_wr_en_out)
      `CHK("skip_busy", 0, busy_out)
      skip = 0;
    end
    else if (i[13:8] == 6'h09 || i[13:8] == 6'h03 || i[13:8] == 6'h0B) begin
      `CHK("busy", 1, busy_out)
      `CHK("addr", i[6:0], file_addr_out)
      `CHK("wr_en", i[7], file_wr_en_out)
      if (i[7]) `CHK("wr_data", r, file_wr_data_out)
      else w = r;
      if (i[13:8] != 6'h0B) z = (r == 0);
      skip = (i[13:8] == 6'h0B && r == 0);
    end
    else begin
      `CHK("wr_en", 0, file_wr_en_out)
      `CHK("busy", 0, busy_out)
    end
    `CHK("w", w, w_out)
    `CHK("zero", z, zero_flag_out)
  endtask
  initial begin
    void'($urandom(99446));
    repeat (20) @(posedge clk_sys_in);
    #1 srst_in = 1'b0;
    op(14'h0913, 8'h13);
    op(14'h0BA5, 8'h01);
    op(14'h09FF, 8'h00);
    op(14'h0B05, 8'h05);
    op(14'h0381, 8'h01);
    repeat (300) begin
      d = ($urandom % 3 == 0) ? 8'h01 : (($urandom % 4 == 0) ? 8'hFF : 8'($urandom));
      op({ops[$urandom % 5], 8'($urandom)}, d);
    end
    srst_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    `CHK("rst_phase", 1, phase_out)
    `CHK("rst_w", 0, w_out)
    `CHK("rst_zero", 0, zero_flag_out)
    `CHK("rst_nop", 0, nop_cycle_out)
    srst_in = 1'b0;
    w = 0;
    z = 0;
    skip = 0;
    op(14'h0B81, 8'h01);
    op(14'h0955, 8'h12);
    op(14'h0302, 8'h00);
    end_of_test();
  end
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
endmodule
